/* File: core/aeb_defines.vh */
// Constants for the almost-empty status bus sequencer.
// Assumes an APB master on pclk and a single device clock.
//
// Behaviour
// [R1] Polled mode when mode select high at reset
// [R2] Polled mode cycles all four quadrants
// [R3] Next quadrant loaded every clock edge
// [R4] Frame mark high only during first quadrant
// [R5] Board sets exactly one chain master
// [R6] Master takes bus first edge after reset
// [R7] Master keeps bus three more cycles
// [R8] Bus outputs released without the token
// [R9] Pass token out during last quadrant
// [R10] Board chains token outputs into a ring
// [R11] Each device drives its own frame mark
// [R12] Lone device loops token output to input
// [R13] Lone device drives bus only with token
// [R14] Bus bit may lag flag one cycle
// [R15] Status bus is eight bits wide
// [R16] Quadrant maps eight queues onto bits 0..7
// [R17] Direct addressed quadrants when mode select low
// [R18] Restart at first quadrant, one-cycle token pulse
`ifndef AEB_DEFINES_VH
`define AEB_DEFINES_VH

// ****************************************
// Register map
// ****************************************
`define AEB_CTRL_OFS 12'h000
`define AEB_STATE_OFS 12'h004
`define AEB_INT_STAT_OFS 12'h008
`define AEB_INT_MASK_OFS 12'h00c

// ****************************************
// Fields
// ****************************************
`define AEB_CTRL_BUS_EN_BIT 0
`define AEB_CTRL_RESET 1'b1
`define AEB_STATE_POLLED_BIT 0
`define AEB_STATE_MASTER_BIT 1
`define AEB_STATE_OWN_BIT 2
`define AEB_STATE_QUAD_LSB 4
`define AEB_EV_TOKEN_IN 0
`define AEB_EV_FRAME 1
`define AEB_EV_TOKEN_OUT 2
`define AEB_EV_DIRECT 3
`define AEB_EV_W 4
`define AEB_INT_MASK_RESET 4'h0

// ****************************************
// Bus geometry
// ****************************************
`define AEB_BUS_W 8
`define AEB_NUM_QUAD 4
`define AEB_LAST_QUAD 2'h3
`define AEB_FIRST_QUAD 2'h0

`endif

/* File: core/aeb_poll_seq.v */
// Almost-empty status bus sequencer, polled or direct quadrant mode,
// with an APB register slave and one level interrupt.
// Assumes all inputs are synchronous to pclk and the board wires the
// token ring and the master select.
`timescale 1ns/1ps
`include "aeb_defines.vh"

module aeb_poll_seq #(
  parameter NUM_QUEUES = 32,
  parameter ID_W = 3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire full_reset_in,
  input wire flag_bus_mode_select,
  input wire chain_master_select,
  input wire [NUM_QUEUES-1:0] almost_empty_flag_n,
  input wire token_pass_in,
  output reg token_pass_out,
  output reg [`AEB_BUS_W-1:0] almost_empty_status_bus_n,
  output reg [`AEB_BUS_W-1:0] almost_empty_status_bus_oe,
  output reg status_bus_frame_mark,
  input wire [ID_W+1:0] read_side_address_bus,
  input wire quadrant_strobe,
  input wire [ID_W-1:0] device_id
);

  // ****************************************
  // Helpers
  // ****************************************
  // Eight consecutive queues of one quadrant onto bits 0..7
  function [`AEB_BUS_W-1:0] quad_slice;
    input [4*`AEB_BUS_W-1:0] flags;
    input [1:0] q;
    begin
      quad_slice = flags[q*`AEB_BUS_W +: `AEB_BUS_W]; // [R15] [R16]
    end
  endfunction

  // ****************************************
  // Configuration caught during full reset
  // ****************************************
  reg polled_reg;
  reg master_reg;
  reg in_reset_reg;
  reg own_reg;
  reg [1:0] quad_reg;
  reg [4*`AEB_BUS_W-1:0] flags_reg;
  reg bus_en_reg;
  reg [`AEB_EV_W-1:0] int_stat_reg;
  reg [`AEB_EV_W-1:0] int_mask_reg;

  wire reset_fall = in_reset_reg & ~full_reset_in;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polled_reg <= 1'b0;
      master_reg <= 1'b0;
      in_reset_reg <= 1'b0;
    end else begin
      in_reset_reg <= full_reset_in;
      if (full_reset_in) begin
        polled_reg <= flag_bus_mode_select; // [R1] [R17]
        master_reg <= chain_master_select; // [R5]
      end
    end
  end

  // Padded flag image; queues above NUM_QUEUES read as not almost empty.
  // The bus output register is why a bus bit may trail the active flag; flags_reg does not feed the bus.
  wire [4*`AEB_BUS_W-1:0] flags_pad;
  generate
    if (NUM_QUEUES < 4*`AEB_BUS_W) begin : g_pad
      assign flags_pad = {{(4*`AEB_BUS_W-NUM_QUEUES){1'b1}},
                          almost_empty_flag_n};
    end else begin : g_nopad
      assign flags_pad = almost_empty_flag_n[4*`AEB_BUS_W-1:0];
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      flags_reg <= {(4*`AEB_BUS_W){1'b1}};
    else
      flags_reg <= flags_pad; // [R14]
  end

  // ****************************************
  // Sequencer
  // ****************************************
  reg own_next;
  reg [1:0] quad_next;
  reg tok_next;
  reg frame_next;
  reg direct_sel;
  reg tok_in_ev;

  always @* begin
    own_next = own_reg;
    quad_next = quad_reg;
    tok_next = 1'b0;
    frame_next = 1'b0;
    direct_sel = 1'b0;
    tok_in_ev = 1'b0;
    if (full_reset_in) begin
      own_next = 1'b0;
      quad_next = `AEB_FIRST_QUAD;
    end else if (polled_reg) begin
      if (own_reg) begin
        if (quad_reg == `AEB_LAST_QUAD) begin
          own_next = 1'b0; // [R8] [R9]
        end else begin
          quad_next = quad_reg + 2'h1; // [R2] [R3] [R7]
          // Hand over during the last quadrant so the next device
          // takes the bus at the edge this one releases it
          tok_next = (quad_next == `AEB_LAST_QUAD); // [R9] [R18]
        end
      end
      if (!own_next && ((reset_fall && master_reg) || // [R6]
          (token_pass_in && !reset_fall))) begin // [R13]
        own_next = 1'b1;
        quad_next = `AEB_FIRST_QUAD; // [R18]
        frame_next = 1'b1; // [R4] [R11]
        tok_in_ev = token_pass_in;
      end
    end else if (quadrant_strobe) begin
      direct_sel = 1'b1;
      own_next = (read_side_address_bus[ID_W+1:2] == device_id); // [R17]
      quad_next = read_side_address_bus[1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_reg <= 1'b0;
      quad_reg <= `AEB_FIRST_QUAD;
      token_pass_out <= 1'b0;
      status_bus_frame_mark <= 1'b0;
      almost_empty_status_bus_n <= {`AEB_BUS_W{1'b1}};
      almost_empty_status_bus_oe <= {`AEB_BUS_W{1'b0}};
    end else begin
      own_reg <= own_next;
      quad_reg <= quad_next;
      token_pass_out <= tok_next; // [R18]
      status_bus_frame_mark <= frame_next; // [R4]
      almost_empty_status_bus_n <= quad_slice(flags_pad, quad_next); // [R3]
      almost_empty_status_bus_oe <=
        {`AEB_BUS_W{own_next & bus_en_reg}}; // [R8] [R13]
    end
  end

  // ****************************************
  // APB slave, one wait state
  // ****************************************
  wire setup_acc = psel & penable & ~pready;
  wire done = psel & penable & pready;
  wire mapped = (paddr == `AEB_CTRL_OFS) || (paddr == `AEB_STATE_OFS) ||
                (paddr == `AEB_INT_STAT_OFS) ||
                (paddr == `AEB_INT_MASK_OFS);
  wire [`AEB_EV_W-1:0] events = {direct_sel, tok_next, frame_next,
                                 tok_in_ev};
  wire stat_rd_clr = done & ~pwrite & (paddr == `AEB_INT_STAT_OFS);
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `AEB_CTRL_OFS: rd_mux[`AEB_CTRL_BUS_EN_BIT] = bus_en_reg;
      `AEB_STATE_OFS: begin
        rd_mux[`AEB_STATE_POLLED_BIT] = polled_reg;
        rd_mux[`AEB_STATE_MASTER_BIT] = master_reg;
        rd_mux[`AEB_STATE_OWN_BIT] = own_reg;
        rd_mux[`AEB_STATE_QUAD_LSB +: 2] = quad_reg;
      end
      `AEB_INT_STAT_OFS: rd_mux[`AEB_EV_W-1:0] = int_stat_reg;
      `AEB_INT_MASK_OFS: rd_mux[`AEB_EV_W-1:0] = int_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      bus_en_reg <= `AEB_CTRL_RESET;
      int_mask_reg <= `AEB_INT_MASK_RESET;
      int_stat_reg <= {`AEB_EV_W{1'b0}};
      irq <= 1'b0;
    end else begin
      pready <= setup_acc;
      pslverr <= setup_acc & ~mapped;
      if (setup_acc)
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      if (done && pwrite && paddr == `AEB_CTRL_OFS)
        bus_en_reg <= pwdata[`AEB_CTRL_BUS_EN_BIT];
      if (done && pwrite && paddr == `AEB_INT_MASK_OFS)
        int_mask_reg <= pwdata[`AEB_EV_W-1:0];
      // An event in the clearing cycle survives the clear
      int_stat_reg <= (stat_rd_clr ? {`AEB_EV_W{1'b0}} : int_stat_reg)
                      | events;
      irq <= |(((stat_rd_clr ? {`AEB_EV_W{1'b0}} : int_stat_reg)
               | events) & int_mask_reg);
    end
  end

endmodule // aeb_poll_seq

/* File: dv/aeb_poll_seq_properties.sv */
// Checker for the status bus sequencer ports.
// Assumes the bench binds it to the sequencer top module.
`timescale 1ns/1ps
module aeb_chk #(parameter NUM_QUEUES = 32) (
  input wire pclk,
  input wire presetn,
  input wire full_reset_in,
  input wire flag_bus_mode_select,
  input wire chain_master_select,
  input wire [NUM_QUEUES-1:0] almost_empty_flag_n,
  input wire token_pass_in,
  input wire token_pass_out,
  input wire [7:0] almost_empty_status_bus_n,
  input wire [7:0] almost_empty_status_bus_oe,
  input wire status_bus_frame_mark
);
  // ****************************************
  // Polled bus properties
  // ****************************************
  wire fm = status_bus_frame_mark;
  wire [7:0] oe = almost_empty_status_bus_oe;
  wire [7:0] bus = almost_empty_status_bus_n;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_tail;
    !fm [*3];
  endsequence
  sequence s_start;
    $fell(full_reset_in) && chain_master_select && flag_bus_mode_select;
  endsequence
  mark_one_a: assert property (fm |=> s_tail)
    else $error("Frame mark held too long");
  tok_slot_a: assert property (fm |-> ##3 token_pass_out)
    else $error("Token not passed in last quadrant");
  tok_pulse_a: assert property (token_pass_out |=> !token_pass_out)
    else $error("Token pulse too long");
  bus_rel_a: assert property
    (token_pass_out && !token_pass_in |=> oe == 8'h00)
    else $error("Bus kept after token left");
  loop_back_a: assert property
    (token_pass_out && token_pass_in |=> fm)
    else $error("Looped token did not restart");
  master_go_a: assert property (s_start |=> fm)
    else $error("Master did not start");
  quad_zero_a: assert property
    (fm && oe[0] |-> bus == $past(almost_empty_flag_n[7:0]))
    else $error("First quadrant wrong");
  quad_one_a: assert property
    ($past(fm) && oe[0] |-> bus == $past(almost_empty_flag_n[15:8]))
    else $error("Second quadrant wrong");
  oe_whole_a: assert property (oe == 8'h00 || oe == 8'hff)
    else $error("Bus enable split");
endmodule // aeb_chk

/* File: dv/aeb_ring_model.sv */
// Token ring model: the rest of the chain hands the token back.
// Assumes tok_out pulses once; ring_en low drops the token.
`timescale 1ns/1ps
module aeb_ring (
  input wire pclk,
  input wire presetn,
  input wire ring_en,
  input wire [2:0] dly,
  input wire tok_out,
  output wire tok_in
);
  // ****************************************
  // Delay line
  // ****************************************
  reg busy_reg;
  reg [2:0] cnt_reg;
  // Zero delay is the lone device loopback
  assign tok_in = ring_en & ((tok_out & dly == 3'h0) | (busy_reg & cnt_reg == 3'h0));
  // Delay latched per token so a change cannot drop one in flight
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      cnt_reg <= 3'h0;
    end else if (tok_out && dly != 3'h0) begin
      busy_reg <= 1'b1;
      cnt_reg <= dly - 3'h1;
    end else if (busy_reg) begin
      busy_reg <= cnt_reg != 3'h0;
      cnt_reg <= cnt_reg - 3'h1;
    end
  end
endmodule // aeb_ring

/* File: dv/aeb_poll_seq_test.sv */
// Bench for the polled status bus sequencer over APB.
// Assumes one master device closed into a ring by the model.
`timescale 1ns/1ps
module aeb_poll_seq_test;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0, frst = 1'b0, ring_en = 1'b1, en = 1'b1, e;
  reg fms = 1'b1, qs = 1'b0, mon = 1'b1;
  reg [4:0] rdaddr = 5'h00;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, flags = 32'hffffffff, flags_d, d;
  reg [2:0] dly = 3'h0, q = 3'h4;
  wire [31:0] prdata;
  wire pready, pslverr, irq, tki, tko, fm;
  wire [7:0] bus, oe;
  integer seed = 32'hd39d, n_fail = 0, samples_checked = 0;
  always #4 pclk = ~pclk;
  aeb_poll_seq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .full_reset_in(frst), .flag_bus_mode_select(fms),
    .chain_master_select(1'b1), .almost_empty_flag_n(flags),
    .token_pass_in(tki), .token_pass_out(tko),
    .almost_empty_status_bus_n(bus), .almost_empty_status_bus_oe(oe),
    .status_bus_frame_mark(fm), .read_side_address_bus(rdaddr),
    .quadrant_strobe(qs), .device_id(3'h0));
  aeb_ring u_ring (.pclk(pclk), .presetn(presetn), .ring_en(ring_en),
    .dly(dly), .tok_out(tko), .tok_in(tki));
  function [7:0] quad(input [31:0] f, input [2:0] k);
    quad = f[8 * k +: 8];
  endfunction
  task cmp(input [32:0] got, input [32:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Hold the request until pready is seen high at a rising edge
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task start;
    begin
      frst <= 1'b1;
      repeat (2) @(posedge pclk);
      frst <= 1'b0;
    end
  endtask
  task run;
    repeat (6) begin
      repeat (12) begin
        @(posedge pclk);
        flags <= $random(seed);
      end
      dly <= $random(seed);
    end
  endtask
  // Direct quadrant select, one strobe, checked the cycle after it
  task dsel(input [4:0] a, input [7:0] exp_oe);
    begin
      @(posedge pclk);
      rdaddr <= a;
      qs <= 1'b1;
      flags <= $random(seed);
      @(posedge pclk);
      qs <= 1'b0;
      @(negedge pclk);
      cmp(oe, exp_oe);
      if (exp_oe != 8'h00) cmp(bus, quad(flags_d, a[1:0]));
      cmp(fm, 1'b0);
    end
  endtask
  task end_of_test;
    begin
      if (n_fail == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge pclk) flags_d <= flags;
  always @(negedge pclk) if (presetn && mon) begin
    q = fm ? 3'h0 : (q == 3'h4 ? q : q + 3'h1);
    cmp(oe, (q != 3'h4 && en) ? 8'hff : 8'h00);
    if (q != 3'h4 && en) cmp(bus, quad(flags_d, q));
    cmp(tko, q == 3'h3);
  end
  initial begin
    #20000;
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    cmp(d, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    cmp(d, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    cmp({e, d}, {1'b1, 32'h0});
    start;
    apb(1'b0, 12'h004, 32'h0);
    cmp(d & 32'h3, 32'h3);
    apb(1'b1, 12'h00c, 32'hf);
    run;
    ring_en <= 1'b0;
    repeat (12) @(negedge pclk);
    cmp(irq, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    cmp(d, 32'h7);
    repeat (2) @(negedge pclk);
    cmp(irq, 1'b0);
    apb(1'b1, 12'h000, 32'h0);
    en = 1'b0;
    ring_en <= 1'b1;
    start;
    run;
    ring_en <= 1'b0;
    repeat (12) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h1);
    en = 1'b1;
    mon = 1'b0;
    fms <= 1'b0;
    start;
    dsel(5'h02, 8'hff);
    dsel(5'h03, 8'hff);
    dsel(5'h04, 8'h00);
    apb(1'b0, 12'h004, 32'h0);
    cmp(d & 32'h1, 32'h0);
    end_of_test;
  end
endmodule // aeb_poll_seq_test
bind aeb_poll_seq aeb_chk #(.NUM_QUEUES(NUM_QUEUES)) u_chk (.pclk(pclk),
  .presetn(presetn), .full_reset_in(full_reset_in),
  .flag_bus_mode_select(flag_bus_mode_select),
  .chain_master_select(chain_master_select),
  .almost_empty_flag_n(almost_empty_flag_n),
  .token_pass_in(token_pass_in), .token_pass_out(token_pass_out),
  .almost_empty_status_bus_n(almost_empty_status_bus_n),
  .almost_empty_status_bus_oe(almost_empty_status_bus_oe),
  .status_bus_frame_mark(status_bus_frame_mark));
